// >>> design/cis_core.sv
// Instruction subset executor with AHB-Lite register access
//
// Operation
// - Clear-working op writes zero to working register and sets zero flag.
// - Decrement-skip subtracts one from file reg; dest bit picks W or file.
// - Increment-skip adds one to file reg; dest bit picks W or file.
// - Zero result of either skip op turns next instruction into a no-op.
// - Branch loads pc low 11 bits from operand, top two from page bits 4:3.
// - Branch takes two cycles; second cycle only keeps the core busy, nothing is discarded.
// - Or-literal ORs working register with 8-bit literal into W.
`timescale 1ns/10ps
module cis_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [cis_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [cis_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [cis_pkg::DATA_W-1:0] hrdata,
  output logic hresp
);
  import cis_pkg::*;

  cis_regs_t q;
  cis_regs_t d;

  // Register map, one word each
  // INSTR  issue word, reads back the last word
  // WREG   working register
  // STATUS zero flag, pending skip, busy
  // PC     program counter
  // PAGE   page latch, bits 4:3 feed the branch
  // FADDR  file pointer
  // FDATA  file register at the pointer
  function automatic logic [31:0] status_word(input cis_regs_t r);
    logic [31:0] s;
    s = '0;
    s[ST_Z_BIT] = r.zflag;
    s[ST_SKIP_BIT] = r.discard;
    s[ST_BUSY_BIT] = (r.st != CIS_IDLE);
    return s;
  endfunction

  function automatic logic [31:0] reg_read(input cis_regs_t r,
                                           input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    if (a == OFS_INSTR) begin
      v[INSTR_W-1:0] = r.instr;
    end else if (a == OFS_WREG) begin
      v[DEC_W-1:0] = r.wreg;
    end else if (a == OFS_STATUS) begin
      v = status_word(r);
    end else if (a == OFS_PC) begin
      v[PC_W-1:0] = r.pc;
    end else if (a == OFS_PAGE) begin
      v[DEC_W-1:0] = r.page;
    end else if (a == OFS_FADDR) begin
      v[FADDR_W-1:0] = r.faddr;
    end else if (a == OFS_FDATA) begin
      v[DEC_W-1:0] = r.file[r.faddr];
    end
    return v;
  endfunction

  // Address phase that starts a transfer
  function automatic logic accept(input logic sel, input logic [1:0] tr);
    return sel && (tr == HTRANS_NONSEQ);
  endfunction

  function automatic logic is_clear_w(input logic [13:0] i);
    return (i & OPC_CLR_W_MASK) == OPC_CLR_W;
  endfunction

  function automatic logic is_dec_skip(input logic [13:0] i);
    return (i & OPC_FILE_MASK) == OPC_DECSKIP;
  endfunction

  function automatic logic is_inc_skip(input logic [13:0] i);
    return (i & OPC_FILE_MASK) == OPC_INCSKIP;
  endfunction

  function automatic logic is_branch(input logic [13:0] i);
    return (i & OPC_BR_MASK) == OPC_BR;
  endfunction

  function automatic logic is_or_lit(input logic [13:0] i);
    return (i & OPC_FILE_MASK) == OPC_ORL;
  endfunction

  // Branch target: page bits above the 11-bit operand
  function automatic logic [12:0] branch_target(input logic [7:0] pg,
                                                input logic [13:0] i);
    return {pg[PAGE_HI:PAGE_LO], i[BR_W-1:0]};
  endfunction

  // One step of a skip op, down or up
  function automatic logic [7:0] skip_step(input logic [7:0] v,
                                           input logic dn);
    logic [7:0] r;
    r = BYTE_ZERO;
    if (dn) begin
      r = v - BYTE_ONE;
    end else begin
      r = v + BYTE_ONE;
    end
    return r;
  endfunction

  // Register write, applied only while the core is idle
  function automatic cis_regs_t reg_write(input cis_regs_t r,
                                          input logic [7:0] a,
                                          input logic [31:0] v);
    cis_regs_t n;
    n = r;
    if (a == OFS_INSTR) begin
      n.instr = v[INSTR_W-1:0];
      n.st = CIS_EXEC;
    end else if (a == OFS_WREG) begin
      n.wreg = v[DEC_W-1:0];
    end else if (a == OFS_STATUS) begin
      n.zflag = v[ST_Z_BIT];
    end else if (a == OFS_PC) begin
      n.pc = v[PC_W-1:0];
    end else if (a == OFS_PAGE) begin
      n.page = v[DEC_W-1:0];
    end else if (a == OFS_FADDR) begin
      n.faddr = v[FADDR_W-1:0];
    end else if (a == OFS_FDATA) begin
      n.file[r.faddr] = v[DEC_W-1:0];
    end
    return n;
  endfunction

  logic idle;
  logic stall;
  logic wr_done;
  logic rd_fetch;
  logic [6:0] op_addr;
  logic [7:0] op_val;
  logic [7:0] op_res;
  logic op_dest;
  logic skip_op;

  assign idle = (q.st == CIS_IDLE);
  // Reads and writes both wait for the core to go idle; reads add one cycle for data
  assign stall = q.dp_valid && (!idle || (!q.dp_write && !q.rd_ready));
  assign hreadyout = !stall;
  assign hrdata = q.hrdata;
  assign hresp = HRESP_OKAY;
  assign wr_done = q.dp_valid && q.dp_write && idle;
  assign rd_fetch = q.dp_valid && !q.dp_write && idle && !q.rd_ready;
  assign op_addr = q.instr[FADDR_W-1:0];
  assign op_val = q.file[op_addr];
  assign op_dest = q.instr[DEST_BIT];
  assign skip_op = is_dec_skip(q.instr) || is_inc_skip(q.instr);

  always_comb begin
    d = q;
    op_res = BYTE_ZERO;
    // Bus address phase
    if (hready) begin
      d.dp_valid = accept(hsel, htrans);
      d.dp_write = hwrite;
      d.dp_addr = haddr[7:0];
      d.rd_ready = 1'b0;
    end
    if (rd_fetch) begin
      d.hrdata = reg_read(q, q.dp_addr);
      d.rd_ready = 1'b1;
    end
    if (wr_done) begin
      d = reg_write(d, q.dp_addr, hwdata);
    end
    // Execution
    case (q.st)
      CIS_IDLE: begin
      end
      CIS_EXEC: begin
        d.st = CIS_IDLE;
        // Every word advances pc; a branch overrides it below
        d.pc = q.pc + PC_ONE;
        if (q.discard) begin
          d.discard = 1'b0;
        end else if (is_clear_w(q.instr)) begin
          d.wreg = BYTE_ZERO;
          d.zflag = 1'b1;
        end else if (skip_op) begin
          op_res = skip_step(op_val, is_dec_skip(q.instr));
          if (op_dest) begin
            d.file[op_addr] = op_res;
          end else begin
            d.wreg = op_res;
          end
          // Zero flag deliberately left alone
          d.discard = (op_res == BYTE_ZERO);
        end else if (is_branch(q.instr)) begin
          d.pc = branch_target(q.page, q.instr);
          d.st = CIS_SECOND;
        end else if (is_or_lit(q.instr)) begin
          d.wreg = q.wreg | q.instr[DEC_W-1:0];
        end
      end
      CIS_SECOND: begin
        d.st = CIS_IDLE;
      end
      default: begin
        d.st = CIS_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.st <= CIS_IDLE;
      q.pc <= PC_RESET;
    end else begin
      q <= d;
    end
  end
endmodule // cis_core

// >>> design/cis_pkg.sv
// Package with register map, encodings and types of the instruction core
package cis_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_WREG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_PAGE = 8'h10;
  localparam logic [7:0] OFS_FADDR = 8'h14;
  localparam logic [7:0] OFS_FDATA = 8'h18;
  localparam int unsigned DEC_W = 8;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned PC_W = 13;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned BR_W = 11;
  localparam int unsigned PAGE_HI = 4;
  localparam int unsigned PAGE_LO = 3;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned ST_Z_BIT = 0;
  localparam int unsigned ST_SKIP_BIT = 1;
  localparam int unsigned ST_BUSY_BIT = 2;
  // Opcode patterns, compared under their masks
  localparam logic [13:0] OPC_CLR_W_MASK = 14'h3F80;
  localparam logic [13:0] OPC_CLR_W = 14'h0100;
  localparam logic [13:0] OPC_FILE_MASK = 14'h3F00;
  localparam logic [13:0] OPC_DECSKIP = 14'h0B00;
  localparam logic [13:0] OPC_INCSKIP = 14'h0F00;
  localparam logic [13:0] OPC_BR_MASK = 14'h3800;
  localparam logic [13:0] OPC_BR = 14'h2800;
  localparam logic [13:0] OPC_ORL = 14'h3800;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [12:0] PC_ONE = 13'h0001;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    CIS_IDLE,
    CIS_EXEC,
    CIS_SECOND
  } cis_state_t;

  typedef struct packed {
    cis_state_t st;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic rd_ready;
    logic [31:0] hrdata;
    logic [13:0] instr;
    logic discard;
    logic [7:0] wreg;
    logic zflag;
    logic [12:0] pc;
    logic [7:0] page;
    logic [6:0] faddr;
    logic [127:0][7:0] file;
  } cis_regs_t;
endpackage

// >>> tb/cis_core_chk.sv
// Bus timing checks for the instruction core
`timescale 1ns/10ps
module cis_core_chk
  import cis_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [DATA_W-1:0] hrdata,
  input wire logic hresp
);
  logic dp_q, rp_q, iw_q, um_q;
  logic [1:0] cnt_q;
  wire t = hsel && hready && htrans == HTRANS_NONSEQ;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {dp_q, rp_q, iw_q, um_q} <= '0;
    end else if (t) begin
      dp_q <= 1'b1;
      rp_q <= !hwrite;
      iw_q <= hwrite && haddr[7:0] == OFS_INSTR;
      um_q <= !hwrite && haddr[7:0] > OFS_FDATA;
    end else if (hreadyout) begin
      {dp_q, rp_q, iw_q, um_q} <= '0;
    end
  end
  // Cycles left until execution of an issued word is over
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_q <= 2'd0;
    else if (iw_q && hreadyout && !t) cnt_q <= 2'd2;
    else if (cnt_q != 2'd0) cnt_q <= cnt_q - 2'd1;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  okay_resp_a: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  read_wait_a: assert property (t && !hwrite |=> !hreadyout)
    else $error("read without wait state");
  read_one_a: assert property (
    t && !hwrite && cnt_q == 2'd0 |=> !hreadyout ##1 hreadyout)
    else $error("idle read not one wait state");
  write_nowait_a: assert property (
    t && hwrite && cnt_q == 2'd0 |=> hreadyout)
    else $error("idle write stalled");
  stall_bound_a: assert property (!hreadyout |-> ##[1:3] hreadyout)
    else $error("stall too long");
  idle_ready_a: assert property (!dp_q |-> hreadyout)
    else $error("ready low outside data phase");
  rdata_hold_a: assert property (!rp_q |=> $stable(hrdata))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (um_q && hreadyout |-> hrdata == '0)
    else $error("unmapped read not zero");
endmodule // cis_core_chk
bind cis_core cis_core_chk cis_core_chk_inst (.*);

// >>> tb/tb.sv
// Random and corner tests of the instruction core over AHB-Lite
`timescale 1ns/10ps
module tb;
  import cis_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sk, z, d;
  logic [1:0] htrans;
  logic [2:0] hsize, op;
  logic [31:0] haddr, hwdata, hrdata, rv, k;
  logic [7:0] w, f, fv, pg, zm;
  logic [12:0] pc;
  logic [13:0] iw;
  int err_count, check_count, seed;
  int ws, nw;
  assign hready = hreadyout;
  cis_core cis_core_inst (.*);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic rdy;
    ws = 0;
    @(negedge hclk);
    while (hready !== 1'b1) begin
      ws++;
      @(negedge hclk);
    end
    rv = hrdata;
    @(posedge hclk);
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] dt);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= 32'(a);
    rdy;
    htrans <= 2'b00;
    hwdata <= dt;
    rdy;
  endtask
  task automatic rd(input logic [7:0] a, input string n,
                    input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, 32'h0000_0000);
    check_count++;
    if ((rv & m) !== (e & m)) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e & m, rv & m);
    end
  endtask
  task automatic cmp_waits(input string n, input int e);
    check_count++;
    if (ws != e) begin
      err_count++;
      $display("BAD %s exp %0d got %0d", n, e, ws);
    end
  endtask
  // Expected effect of one issued word, pending skip first
  function automatic void exec(input logic [13:0] i);
    logic [7:0] r;
    r = (op == 3'd1) ? fv - 8'h01 : fv + 8'h01;
    pc = pc + PC_ONE;
    if (sk) sk = 1'b0;
    else case (op)
      3'd0: {w, z} = {8'h00, 1'b1};
      3'd1, 3'd2: begin
        if (i[DEST_BIT]) fv = r;
        else w = r;
        sk = (r == 8'h00);
      end
      3'd3: pc = {pg[4:3], i[10:0]};
      default: w = w | i[7:0];
    endcase
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    $display("BAD watchdog exp done got hang");
    wrap_up;
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, hresetn} = '0;
    {pc, w, z, sk, err_count, check_count} = '0;
    hsize = 3'b010;
    seed = 32'ha8b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 60; i++) begin
      {f, w, pg, k} = 56'({$random(seed), $random(seed)});
      fv = (i % 3 == 0) ? 8'h01 : (i % 3 == 1) ? 8'hFF : k[31:24];
      {z, d} = k[12:11];
      op = 3'($unsigned($random(seed)) % 5);
      xfer(1'b1, OFS_FADDR, 32'(f[6:0]));
      xfer(1'b1, OFS_FDATA, 32'(fv));
      xfer(1'b1, OFS_WREG, 32'(w));
      xfer(1'b1, OFS_STATUS, 32'(z));
      xfer(1'b1, OFS_PAGE, 32'(pg));
      case (op)
        3'd0: iw = OPC_CLR_W | 14'(k[6:0]);
        3'd1: iw = OPC_DECSKIP | 14'({d, f[6:0]});
        3'd2: iw = OPC_INCSKIP | 14'({d, f[6:0]});
        3'd3: iw = OPC_BR | 14'(k[10:0]);
        default: iw = OPC_ORL | 14'(k[7:0]);
      endcase
      zm = (op == 3'd4 && !sk) ? 8'h06 : 8'h07;
      nw = (op == 3'd3 && !sk) ? 2 : 1;
      exec(iw);
      xfer(1'b1, OFS_INSTR, 32'(iw));
      rd(OFS_WREG, "wreg", 32'(w), '1);
      cmp_waits("waits", nw);
      rd(OFS_FDATA, "file", 32'(fv), '1);
      rd(OFS_STATUS, "status", 32'({sk, z}), 32'(zm));
      rd(OFS_PC, "pc", 32'(pc), '1);
    end
    $display("test random ops done");
    xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, "unmapped", 32'h0000_0000, '1);
    $display("test unmapped done");
    wrap_up;
  end
endmodule // tb
